/* pfd_pkg.sv */
/*
 * pfd_pkg: register map, field positions and reset values of the
 * programmable tone divider.
 * assumes: plain register port with 8-bit address and data.
 */
package pfd_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;

    // register offsets
    localparam logic [7:0]  CTRL_ADDR       = 8'h2E;
    localparam logic [7:0]  DATA_ADDR       = 8'h2F;
    localparam logic [7:0]  STAT_ADDR       = 8'h30;

    // control register fields
    localparam int          CTRL_EN_BIT     = 0;
    localparam int          CTRL_CLKSEL_BIT = 1;
    localparam int          CTRL_PRESCALE_SEL_BIT0_BIT  = 2;
    localparam int          CTRL_PRESCALE_SEL_BIT1_BIT  = 3;
    localparam logic [7:0]  CTRL_MASK       = 8'h0F;

    // status register fields
    localparam int          STAT_OUT_BIT    = 0;
    localparam int          STAT_RUN_BIT    = 1;

    // reset values
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  DATA_RESET      = 8'h00;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;

    // source clocks
    localparam int          SYS_CLK_HZ      = 50_000_000;
    localparam int          MAIN_OSC_HZ     = 3_580_000;
    localparam int          MAIN_OSC_DIV    = 4;
    localparam int          WATCH_OSC_HZ    = 32_768;
    localparam int          FAST_SRC_HZ     = MAIN_OSC_HZ / MAIN_OSC_DIV;

    // prescale select codes
    typedef enum logic [1:0] {
        PFD_PRE_DIV1,
        PFD_PRE_DIV2,
        PFD_PRE_DIV4,
        PFD_PRE_DIV8
    } pfd_pre_t;

endpackage : pfd_pkg

/* pfd_src_tick.sv */
`timescale 1ns/1ps
/*
 * pfd_src_tick: fractional rate generator that turns the system clock
 * into a one-cycle enable pulse at a chosen source frequency.
 * assumes: system clock well above the wanted rate.
 */
module pfd_src_tick #(
    parameter int CLK_HZ = 50_000_000,
    parameter int OUT_HZ = 32_768
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // control
    input  wire logic i_run,
    // enable pulse
    output logic      o_tick
);

    localparam int ACC_W = 32;
    localparam logic [ACC_W-1:0] STEP  = ACC_W'(OUT_HZ);
    localparam logic [ACC_W-1:0] LIMIT = ACC_W'(CLK_HZ);

    initial begin
        if (OUT_HZ <= 0 || OUT_HZ * 2 > CLK_HZ) begin
            $error("pfd_src_tick: rate out of range");
        end
    end

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic             next_tick;

    // phase accumulator: average rate exact, jitter one system cycle
    always_comb begin
        next_acc  = acc + STEP;
        next_tick = 1'b0;
        if (!i_run) begin
            next_acc = '0;
        end else if (next_acc >= LIMIT) begin
            next_acc  = next_acc - LIMIT;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc    <= '0;
            o_tick <= 1'b0;
        end else begin
            acc    <= next_acc;
            o_tick <= next_tick;
        end
    end

endmodule // pfd_src_tick

/* pfd_tone_divider.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
/*
 * pfd_tone_divider: programmable tone divider. source select, prescaler
 * and 8-bit reloadable counter drive a square-wave tone pin.
 * assumes: register master on i_mclk; one read or write per cycle.
 */
//
// Function
// - prescaler ratio set by two control bits
// - 8-bit divide value sets general counter
// - source is main osc /4 or watch
// - output toggles only while enable is one
// - data writes ignored while disabled
// - disabling clears the data register
// - output toggles every N+1 prescaler periods
module pfd_tone_divider #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_n,
    // register port
    input  wire logic [pfd_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [pfd_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [pfd_pkg::DATA_W-1:0]  o_rdata,
    // tone pin
    output logic                             o_tone
);

    initial begin
        if (CNT_W != pfd_pkg::DATA_W) begin
            $error("pfd_tone_divider: counter width must match data");
        end
    end

    ////////////////////////////////////////////////////////////////////////

    logic [7:0]       divider_control_reg;
    logic [CNT_W-1:0] divider_count_value;
    logic             divider_output_enable;
    logic             clk_sel_watch;
    logic [1:0]       pre_sel;

    assign divider_output_enable =
        divider_control_reg[pfd_pkg::CTRL_EN_BIT];
    assign clk_sel_watch = divider_control_reg[pfd_pkg::CTRL_CLKSEL_BIT];

    assign pre_sel = {divider_control_reg[pfd_pkg::CTRL_PRESCALE_SEL_BIT1_BIT],
                      divider_control_reg[pfd_pkg::CTRL_PRESCALE_SEL_BIT0_BIT]};

    function automatic logic hit(input logic [pfd_pkg::ADDR_W-1:0] a,
                                 input logic [pfd_pkg::ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    // control register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            divider_control_reg <= pfd_pkg::CTRL_RESET;
        end else if (i_wr && hit(i_addr, pfd_pkg::CTRL_ADDR)) begin
            divider_control_reg <= i_wdata & pfd_pkg::CTRL_MASK;
        end
    end

    // data register: written only while enabled, cleared when disabled
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            divider_count_value <= pfd_pkg::DATA_RESET;
        end else if (!divider_output_enable) begin
            divider_count_value <= pfd_pkg::DATA_RESET;
        end else if (i_wr && hit(i_addr, pfd_pkg::DATA_ADDR)) begin
            divider_count_value <= i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source clocks as enable pulses

    logic fast_tick;
    logic slow_tick;
    logic src_tick;

    pfd_src_tick #(
        .CLK_HZ (pfd_pkg::SYS_CLK_HZ),
        .OUT_HZ (pfd_pkg::FAST_SRC_HZ)
    ) u_fast (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (divider_output_enable),
        .o_tick  (fast_tick)
    );

    pfd_src_tick #(
        .CLK_HZ (pfd_pkg::SYS_CLK_HZ),
        .OUT_HZ (pfd_pkg::WATCH_OSC_HZ)
    ) u_slow (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (divider_output_enable),
        .o_tick  (slow_tick)
    );

    assign src_tick = clk_sel_watch ? slow_tick : fast_tick;

    ////////////////////////////////////////////////////////////////////////
    // prescaler

    logic [2:0] pre_cnt;
    logic       pre_tick;

    function automatic logic pre_done(input logic [1:0] sel,
                                      input logic [2:0] cnt);
        case (sel)
            pfd_pkg::PFD_PRE_DIV1: pre_done = 1'b1;
            pfd_pkg::PFD_PRE_DIV2: pre_done = cnt[0];
            pfd_pkg::PFD_PRE_DIV4: pre_done = &cnt[1:0];
            pfd_pkg::PFD_PRE_DIV8: pre_done = &cnt;
            default: pre_done = 1'b1;
        endcase
    endfunction

    assign pre_tick = src_tick && pre_done(pre_sel, pre_cnt);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_cnt <= 3'h0;
        end else if (!divider_output_enable) begin
            pre_cnt <= 3'h0;
        end else if (src_tick) begin
            pre_cnt <= pre_cnt + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general counter and tone output

    logic [CNT_W-1:0] gen_cnt;

    // counter reloads to zero after N+1 prescaled periods; a new value
    // is compared from the next prescaled tick, inside the current half period
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gen_cnt <= '0;
            o_tone  <= 1'b0;
        end else if (!divider_output_enable) begin
            gen_cnt <= '0;
            o_tone  <= 1'b0;
        end else if (pre_tick) begin
            if (gen_cnt >= divider_count_value) begin
                gen_cnt <= '0;
                o_tone  <= ~o_tone;
            end else begin
                gen_cnt <= gen_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= pfd_pkg::ZERO_BYTE;
        end else if (i_rd) begin
            o_rdata <= pfd_pkg::ZERO_BYTE;
            if (hit(i_addr, pfd_pkg::CTRL_ADDR)) begin
                o_rdata <= divider_control_reg;
            end else if (hit(i_addr, pfd_pkg::DATA_ADDR)) begin
                o_rdata <= divider_count_value;
            end else if (hit(i_addr, pfd_pkg::STAT_ADDR)) begin
                o_rdata[pfd_pkg::STAT_OUT_BIT] <= o_tone;
                o_rdata[pfd_pkg::STAT_RUN_BIT] <= divider_output_enable;
            end
        end else begin
            o_rdata <= pfd_pkg::ZERO_BYTE;
        end
    end

endmodule // pfd_tone_divider

/* pfd_checker.sv */
/*
 * pfd_checker: port-level assertions for the tone divider.
 * assumes: bound to pfd_tone_divider, one clock domain.
 */
`timescale 1ns/1ps
module pfd_checker #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic                       i_mclk,
    input wire logic                       i_rst_n,
    // register port
    input wire logic [pfd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pfd_pkg::DATA_W-1:0] i_wdata,
    input wire logic                       i_wr,
    input wire logic                       i_rd,
    input wire logic [pfd_pkg::DATA_W-1:0] o_rdata,
    // tone pin
    input wire logic                       o_tone
);
    logic [7:0] ctrl;
    logic [7:0] data;
    logic       prev;
    logic       valid;
    int         gap;
    longint     e;
    wire        tog = o_tone != prev;
    wire        en  = ctrl[0];
    wire        rc  = i_rd && i_addr == pfd_pkg::CTRL_ADDR;
    wire        rdt = i_rd && i_addr == pfd_pkg::DATA_ADDR;
    wire        rs  = i_rd && i_addr == pfd_pkg::STAT_ADDR;
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n) ctrl <= 8'h00;
        else if (i_wr && i_addr == pfd_pkg::CTRL_ADDR)
            ctrl <= i_wdata & pfd_pkg::CTRL_MASK;
    always_ff @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n) data <= 8'h00;
        else if (!en) data <= 8'h00;
        else if (i_wr && i_addr == pfd_pkg::DATA_ADDR) data <= i_wdata;
    // any write may shift the phase, so the next interval is not judged
    always_ff @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n) begin
            prev  <= 1'b0;
            gap   <= 0;
            valid <= 1'b0;
        end else begin
            prev  <= o_tone;
            gap   <= tog ? 1 : gap + 1;
            valid <= i_wr ? 1'b0 : (tog | valid);
        end
    always_comb
        e = longint'((int'(data) + 1) << ctrl[3:2]) * pfd_pkg::SYS_CLK_HZ
            / (ctrl[1] ? pfd_pkg::WATCH_OSC_HZ : pfd_pkg::FAST_SRC_HZ);
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
    property p_unmap; i_rd && !rc && !rdt && !rs |=> o_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_ctrl_rd; rc |=> o_rdata == $past(ctrl); endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
    property p_data_rd; en && rdt |=> o_rdata == $past(data); endproperty
    a_data_rd: assert property (p_data_rd) else $error("data read");
    property p_data_off; !en && !$past(en, 2) && rdt |=> o_rdata == 8'h00;
    endproperty
    a_data_off: assert property (p_data_off) else $error("data kept");
    property p_tone_off; !en && !$past(en, 2) |-> !o_tone; endproperty
    a_tone_off: assert property (p_tone_off) else $error("tone while off");
    property p_period; tog && valid && en |-> gap >= e - 1 && gap <= e + 2;
    endproperty
    a_period: assert property (p_period) else $error("tone period");
    property p_stuck; en && valid |-> gap <= e + 2; endproperty
    a_stuck: assert property (p_stuck) else $error("tone stuck");
    property p_stat; rs |=> o_rdata[7:2] == 6'h00 && o_rdata[1] == $past(en)
        && o_rdata[0] == $past(o_tone);
    endproperty
    a_stat: assert property (p_stat) else $error("status read");
endmodule // pfd_checker

/* test_pfd_tone_divider.sv */
/*
 * test_pfd_tone_divider: register and tone period tests.
 * assumes: pfd_pkg compiled first; 50 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module test_pfd_tone_divider;
    logic       i_mclk  = 1'b0;
    logic       i_rst_n = 1'b0;
    logic [7:0] i_addr  = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr    = 1'b0;
    logic       i_rd    = 1'b0;
    logic [7:0] o_rdata;
    logic       o_tone;
    logic [7:0] v;
    logic [7:0] n;
    logic [1:0] p;
    int         error_cnt  = 0;
    int         n_compared = 0;
    int         g;
    pfd_tone_divider uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_tone(o_tone));
    initial forever #10 i_mclk = ~i_mclk;
    ////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        d = o_rdata;
    endtask
    // the first intervals after a write may carry the old phase
    task automatic gap(output int c);
        logic t;
        repeat (3) begin
            c = 0;
            t = o_tone;
            while (o_tone === t && c < 40000) begin
                @(negedge i_mclk);
                c++;
            end
        end
    endtask
    function automatic bit near(int c, int k, int hz);
        longint e;
        e = longint'(k) * pfd_pkg::SYS_CLK_HZ / hz;
        return c >= e - 1 && c <= e + 2;
    endfunction
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        error_cnt++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hF310C56E));
        repeat (5) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(pfd_pkg::CTRL_ADDR, v); `CHK(v, pfd_pkg::CTRL_RESET)
        rd(8'h55, v); `CHK(v, 8'h00)
        wr(pfd_pkg::DATA_ADDR, 8'hA5);
        rd(pfd_pkg::DATA_ADDR, v); `CHK(v, 8'h00)
        `CHK(o_tone, 1'b0)
        for (int i = 0; i < 4; i++) begin
            p = i[1:0];
            n = 8'($urandom_range(3));
            wr(pfd_pkg::CTRL_ADDR, {4'($urandom), p, 2'b01});
            wr(pfd_pkg::DATA_ADDR, n);
            rd(pfd_pkg::CTRL_ADDR, v); `CHK(v, {4'h0, p, 2'b01})
            rd(pfd_pkg::DATA_ADDR, v); `CHK(v, n)
            gap(g);
            `CHK(near(g, (int'(n) + 1) << p, pfd_pkg::FAST_SRC_HZ), 1'b1)
        end
        wr(pfd_pkg::CTRL_ADDR, 8'h03);
        wr(pfd_pkg::DATA_ADDR, 8'h01);
        rd(pfd_pkg::STAT_ADDR, v); `CHK(v[1], 1'b1)
        gap(g); `CHK(near(g, 2, pfd_pkg::WATCH_OSC_HZ), 1'b1)
        wr(pfd_pkg::CTRL_ADDR, 8'h00);
        rd(pfd_pkg::DATA_ADDR, v); `CHK(v, 8'h00)
        `CHK(o_tone, 1'b0)
        complete_run();
    end
endmodule // test_pfd_tone_divider
bind pfd_tone_divider pfd_checker #(.CNT_W(CNT_W)) u_chk (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_tone(o_tone));
